// File: hdl/sfcfe_top.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: sample input on serial clock rise, launch output on fall; mode 0 or 3.
// RULE2: select high with nothing running means standby.
// RULE3: unknown command: standby, outputs released, until next select fall.
// RULE4: known command: active until select rises.
// RULE5: read commands stream data out; host may end after any bit.
// RULE6: write-type commands execute only if select rises on a byte boundary.
// RULE7: while program or erase runs, array accesses are ignored.
// RULE8: program one 32-byte page; erase sector, block or whole array.
// RULE9: 4 KB sectors on 0x1000 steps; small variant ends at 00FFFFh.
// RULE10: large variant adds block of sectors 16 to 31, up to 01FFFFh.
// RULE11: status byte carries a busy bit the host can poll.
// RULE12: host should read status before each command.
// RULE13: pause starts when pause pin low and serial clock low.
// RULE14: pause ends when pause pin high and serial clock low.
// RULE15: during pause outputs float, data and clock ignored.
// RULE16: pause never stops a running status write, program or erase.
// RULE17: select rising in pause resets the interface logic.
// RULE18: reset returns to standby; array changes only after valid sequence.
// RULE19: modifying commands need the latch; listed completions clear it.
// RULE20: protect level: 00 none, 01 one block on large, else all.
// RULE21: protect pin low freezes level bits and status lock bit.
// RULE22: in deep power-down only powerdown exit is accepted.
// RULE23: protect and pause pins become data lines 2 and 3 in quad.
// RULE24: a pin in quad data use is not read as protect or pause.
module sfcfe_top #(
  parameter bit LARGE_VARIANT = 1'b1,
  // identification bytes: arbitrary values
  parameter logic [7:0] ID_MAKER = 8'h5a,
  parameter logic [7:0] ID_TYPE = 8'h3c,
  parameter logic [7:0] ID_PART = 8'h01
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // serial pins
  input wire logic select_n_pin,
  input wire logic serial_clock,
  input wire logic data_in_line0,
  output logic data_in_line0_drv,
  output logic data_in_line0_oe,
  input wire logic data_out_line1,
  output logic data_out_line1_drv,
  output logic data_out_line1_oe,
  input wire logic protect_n_pin,
  output logic protect_n_pin_drv,
  output logic protect_n_pin_oe,
  input wire logic pause_n_pin,
  output logic pause_n_pin_drv,
  output logic pause_n_pin_oe,
  // array back end
  input wire logic array_busy,
  output logic op_start,
  output sfcfe_pkg::sfcfe_op_type op_kind,
  output logic [23:0] op_addr,
  output logic [23:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic [7:0] prog_data,
  output logic prog_valid,
  input wire logic prog_ready,
  output logic prog_flush,
  // status
  output logic write_in_progress,
  output logic write_enable_latch,
  output logic protect_level_bit0,
  output logic protect_level_bit1,
  output logic status_write_disable,
  output logic deep_powerdown,
  output logic standby,
  output logic page_overrun
);
  localparam logic [23:0] TOP =
    LARGE_VARIANT ? sfcfe_pkg::LARGE_TOP : sfcfe_pkg::SMALL_TOP;

  logic [5:0] pin_s;
  logic seln;
  logic sclk;
  logic [3:0] io;
  logic sclk_d_r;
  logic seln_d_r;
  logic sel_rise;
  logic sel_fall;
  logic pause_r;
  logic quad_r;
  logic pause_req;
  logic hw_protect;
  logic sclk_rise;
  logic sclk_fall;
  sfcfe_pkg::sfcfe_state_type state_r;
  sfcfe_pkg::sfcfe_state_type dec_state;
  logic [7:0] cmd_r;
  logic [23:0] in_sr_r;
  logic [23:0] in_next;
  logic [4:0] cnt_r;
  logic [4:0] cnt_next;
  logic [2:0] lanes_in;
  logic [2:0] lanes_out;
  logic [2:0] frac_r;
  logic [5:0] nbytes_r;
  logic [7:0] sw_byte_r;
  logic [23:0] addr_r;
  logic addr_done;
  logic byte_done;
  logic [7:0] out_sr_r;
  logic [2:0] ocnt_r;
  logic [3:0] dout_r;
  logic [1:0] id_idx_r;
  logic [7:0] next_byte;
  logic [7:0] cur_byte;
  logic out_load;
  logic [7:0] status_byte;
  logic [1:0] level_r;
  logic frame_ok;
  logic in_wait;
  logic in_data;
  logic is_block;
  logic do_erase;
  logic do_prog;
  logic do_swr;
  logic do_flush;
  logic push_valid;
  logic push_ready;
  logic driving;

  function automatic logic prot_hit(input logic [23:0] a,
                                    input logic [1:0] lv);
    if (lv == sfcfe_pkg::LEVEL_NONE) begin
      prot_hit = 1'b0;
    end else if (LARGE_VARIANT && lv == sfcfe_pkg::LEVEL_ONE_BLOCK) begin
      prot_hit = a[sfcfe_pkg::UPPER_BLOCK_POS];
    end else begin
      prot_hit = 1'b1;
    end
  endfunction : prot_hit

  function automatic sfcfe_pkg::sfcfe_state_type decode(
      input logic [7:0] c, input logic dp, input logic busy);
    if (dp) begin
      decode = (c == sfcfe_pkg::CMD_POWERDOWN_EXIT) ?
        sfcfe_pkg::ST_WAIT : sfcfe_pkg::ST_IGNORE; // [RULE22]
    end else if (busy) begin
      // only status polling gets through while the algorithm runs
      decode = (c == sfcfe_pkg::CMD_STATUS_READ) ?
        sfcfe_pkg::ST_DATA_OUT : sfcfe_pkg::ST_IGNORE; // [RULE7]
    end else begin
      case (c)
        sfcfe_pkg::CMD_WRITE_ENABLE, sfcfe_pkg::CMD_WRITE_DISABLE,
        sfcfe_pkg::CMD_POWERDOWN_ENTER, sfcfe_pkg::CMD_POWERDOWN_EXIT,
        sfcfe_pkg::CMD_CHIP_ERASE_A, sfcfe_pkg::CMD_CHIP_ERASE_B:
          decode = sfcfe_pkg::ST_WAIT; // [RULE4]
        sfcfe_pkg::CMD_STATUS_WRITE:
          decode = sfcfe_pkg::ST_DATA_IN;
        sfcfe_pkg::CMD_ID_READ, sfcfe_pkg::CMD_STATUS_READ:
          decode = sfcfe_pkg::ST_DATA_OUT; // [RULE5]
        sfcfe_pkg::CMD_ARRAY_READ, sfcfe_pkg::CMD_FAST_READ,
        sfcfe_pkg::CMD_DUAL_READ, sfcfe_pkg::CMD_QUAD_IO_READ,
        sfcfe_pkg::CMD_SECTOR_ERASE, sfcfe_pkg::CMD_BLOCK_ERASE_A,
        sfcfe_pkg::CMD_BLOCK_ERASE_B, sfcfe_pkg::CMD_PAGE_PROGRAM:
          decode = sfcfe_pkg::ST_ADDR;
        default:
          decode = sfcfe_pkg::ST_IGNORE; // [RULE3]
      endcase
    end
  endfunction : decode

  sfcfe_sync #(
    .WIDTH(sfcfe_pkg::PIN_COUNT),
    .INIT(sfcfe_pkg::PIN_IDLE)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din({pause_n_pin, protect_n_pin, data_out_line1, data_in_line0,
          serial_clock, select_n_pin}),
    .dout(pin_s)
  );

  assign seln = pin_s[0];
  assign sclk = pin_s[1];
  assign io = pin_s[5:2];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_r <= 1'b1;
      seln_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk;
      seln_d_r <= seln;
    end
  end

  assign sel_rise = seln & ~seln_d_r;
  assign sel_fall = ~seln & seln_d_r;
  assign pause_req = ~io[3] & ~quad_r; // [RULE24]
  assign hw_protect = ~io[2] & ~quad_r; // [RULE24]

  // pause follows the pin only while the serial clock is low; select high clears it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pause_r <= 1'b0;
    end else if (seln) begin
      pause_r <= 1'b0; // [RULE17]
    end else if (!sclk) begin
      pause_r <= pause_req; // [RULE13] [RULE14]
    end
  end

  // both polarities work: only edges inside select low count
  assign sclk_rise = sclk & ~sclk_d_r & ~seln & ~pause_r; // [RULE1] [RULE15]
  assign sclk_fall = ~sclk & sclk_d_r & ~seln & ~pause_r; // [RULE1] [RULE15]

  assign lanes_in = (state_r == sfcfe_pkg::ST_ADDR && quad_r) ?
    sfcfe_pkg::LANES_QUAD : sfcfe_pkg::LANES_SINGLE;
  assign in_next = (lanes_in == sfcfe_pkg::LANES_QUAD) ?
    {in_sr_r[19:0], io} : {in_sr_r[22:0], io[0]};
  assign cnt_next = cnt_r + {2'h0, lanes_in};
  assign dec_state = decode(in_next[7:0], deep_powerdown, write_in_progress);
  assign addr_done = sclk_rise && state_r == sfcfe_pkg::ST_ADDR &&
    cnt_next == sfcfe_pkg::ADDR_BITS;
  assign byte_done = sclk_rise && state_r == sfcfe_pkg::ST_DATA_IN &&
    cnt_next == sfcfe_pkg::CMD_BITS;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= sfcfe_pkg::ST_IDLE; // [RULE18]
      cmd_r <= 8'h00;
      in_sr_r <= 24'h000000;
      cnt_r <= 5'h00;
      quad_r <= 1'b0;
    end else if (seln) begin
      state_r <= sfcfe_pkg::ST_IDLE; // [RULE2] [RULE4]
      cnt_r <= 5'h00;
      quad_r <= 1'b0;
    end else if (sel_fall) begin
      state_r <= sfcfe_pkg::ST_CMD;
      cnt_r <= 5'h00;
    end else if (sclk_rise) begin
      in_sr_r <= in_next;
      cnt_r <= cnt_next;
      case (state_r)
        sfcfe_pkg::ST_CMD: begin
          if (cnt_next == sfcfe_pkg::CMD_BITS) begin
            cmd_r <= in_next[7:0];
            state_r <= dec_state;
            cnt_r <= 5'h00;
            quad_r <= dec_state == sfcfe_pkg::ST_ADDR &&
              in_next[7:0] == sfcfe_pkg::CMD_QUAD_IO_READ; // [RULE23]
          end
        end
        sfcfe_pkg::ST_ADDR: begin
          if (cnt_next == sfcfe_pkg::ADDR_BITS) begin
            cnt_r <= 5'h00;
            case (cmd_r)
              sfcfe_pkg::CMD_ARRAY_READ:
                state_r <= sfcfe_pkg::ST_DATA_OUT;
              sfcfe_pkg::CMD_FAST_READ, sfcfe_pkg::CMD_DUAL_READ,
              sfcfe_pkg::CMD_QUAD_IO_READ:
                state_r <= sfcfe_pkg::ST_DUMMY;
              sfcfe_pkg::CMD_PAGE_PROGRAM:
                state_r <= (write_enable_latch && !prot_hit(in_next, level_r))
                  ? sfcfe_pkg::ST_DATA_IN : sfcfe_pkg::ST_IGNORE; // [RULE19]
              default:
                state_r <= sfcfe_pkg::ST_WAIT;
            endcase
          end
        end
        sfcfe_pkg::ST_DUMMY: begin
          if (cnt_next == (quad_r ? sfcfe_pkg::QUAD_DUMMY_CLKS :
                           sfcfe_pkg::FAST_DUMMY_CLKS)) begin
            state_r <= sfcfe_pkg::ST_DATA_OUT;
            cnt_r <= 5'h00;
          end
        end
        sfcfe_pkg::ST_DATA_IN: begin
          if (cnt_next == sfcfe_pkg::CMD_BITS) begin
            cnt_r <= 5'h00;
          end
        end
        default: begin
          cnt_r <= 5'h00;
        end
      endcase
    end
  end

  // frame bookkeeping for the byte boundary check
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      frac_r <= 3'h0;
      nbytes_r <= 6'h00;
      sw_byte_r <= 8'h00;
      page_overrun <= 1'b0;
    end else begin
      if (sel_fall) begin
        frac_r <= 3'h0;
        nbytes_r <= 6'h00;
      end else if (sclk_rise) begin
        frac_r <= frac_r + lanes_in; // [RULE6]
      end
      if (byte_done) begin
        sw_byte_r <= in_next[7:0];
        if (nbytes_r != sfcfe_pkg::NBYTES_MAX) begin
          nbytes_r <= nbytes_r + 6'h01;
        end
      end
      // a lost byte beats the clear at frame start
      if (push_valid && !push_ready) begin
        page_overrun <= 1'b1;
      end else if (sel_fall) begin
        page_overrun <= 1'b0;
      end
    end
  end

  // sequential reads wrap at the top of the array
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addr_r <= 24'h000000;
    end else if (addr_done) begin
      addr_r <= in_next & TOP; // [RULE9] [RULE10]
    end else if (out_load && cmd_r != sfcfe_pkg::CMD_STATUS_READ &&
                 cmd_r != sfcfe_pkg::CMD_ID_READ) begin
      addr_r <= (addr_r + 24'h000001) & TOP;
    end
  end

  assign rd_addr = addr_r;

  assign status_byte = {status_write_disable, 3'h0, level_r,
                        write_enable_latch, write_in_progress}; // [RULE11]

  always_comb begin
    lanes_out = sfcfe_pkg::LANES_SINGLE;
    if (cmd_r == sfcfe_pkg::CMD_DUAL_READ) begin
      lanes_out = sfcfe_pkg::LANES_DUAL;
    end else if (cmd_r == sfcfe_pkg::CMD_QUAD_IO_READ) begin
      lanes_out = sfcfe_pkg::LANES_QUAD;
    end
  end

  always_comb begin
    case (cmd_r)
      sfcfe_pkg::CMD_STATUS_READ: next_byte = status_byte;
      sfcfe_pkg::CMD_ID_READ: begin
        case (id_idx_r)
          2'h0: next_byte = ID_MAKER;
          2'h1: next_byte = ID_TYPE;
          default: next_byte = ID_PART;
        endcase
      end
      default: next_byte = rd_data;
    endcase
  end

  assign out_load = sclk_fall && state_r == sfcfe_pkg::ST_DATA_OUT &&
    ocnt_r == 3'h0;
  assign cur_byte = (ocnt_r == 3'h0) ? next_byte : out_sr_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_sr_r <= 8'h00;
      ocnt_r <= 3'h0;
      dout_r <= 4'h0;
      id_idx_r <= 2'h0;
    end else if (seln) begin
      ocnt_r <= 3'h0;
      id_idx_r <= 2'h0;
    end else if (sclk_fall && state_r == sfcfe_pkg::ST_DATA_OUT) begin
      dout_r <= cur_byte[7:4]; // [RULE1] [RULE5]
      out_sr_r <= cur_byte << lanes_out;
      ocnt_r <= ocnt_r + lanes_out;
      if (out_load && cmd_r == sfcfe_pkg::CMD_ID_READ) begin
        id_idx_r <= (id_idx_r == sfcfe_pkg::ID_LAST) ? 2'h0 :
          id_idx_r + 2'h1;
      end
    end
  end

  assign driving = state_r == sfcfe_pkg::ST_DATA_OUT && !seln &&
    !pause_r; // [RULE3] [RULE15]
  assign data_out_line1_drv = (lanes_out == sfcfe_pkg::LANES_QUAD) ?
    dout_r[1] : dout_r[3];
  assign data_in_line0_drv = (lanes_out == sfcfe_pkg::LANES_QUAD) ?
    dout_r[0] : dout_r[2];
  assign protect_n_pin_drv = dout_r[2];
  assign pause_n_pin_drv = dout_r[3];
  assign data_out_line1_oe = driving;
  assign data_in_line0_oe = driving &&
    lanes_out != sfcfe_pkg::LANES_SINGLE; // [RULE23]
  assign protect_n_pin_oe = driving &&
    lanes_out == sfcfe_pkg::LANES_QUAD; // [RULE23]
  assign pause_n_pin_oe = driving &&
    lanes_out == sfcfe_pkg::LANES_QUAD; // [RULE23]

  // end of frame: execute only on a clean byte boundary outside pause
  assign frame_ok = sel_rise && !pause_r &&
    frac_r == 3'h0; // [RULE6] [RULE17]
  assign in_wait = state_r == sfcfe_pkg::ST_WAIT;
  assign in_data = state_r == sfcfe_pkg::ST_DATA_IN && nbytes_r != 6'h00;
  assign is_block = cmd_r == sfcfe_pkg::CMD_BLOCK_ERASE_A ||
    cmd_r == sfcfe_pkg::CMD_BLOCK_ERASE_B;
  assign do_erase = frame_ok && in_wait && write_enable_latch &&
    (((cmd_r == sfcfe_pkg::CMD_SECTOR_ERASE || is_block) &&
      !prot_hit(addr_r, level_r)) ||
     ((cmd_r == sfcfe_pkg::CMD_CHIP_ERASE_A ||
       cmd_r == sfcfe_pkg::CMD_CHIP_ERASE_B) &&
      level_r == sfcfe_pkg::LEVEL_NONE)); // [RULE19] [RULE20]
  assign do_prog = frame_ok && in_data &&
    cmd_r == sfcfe_pkg::CMD_PAGE_PROGRAM;
  assign do_swr = frame_ok && in_data && write_enable_latch &&
    cmd_r == sfcfe_pkg::CMD_STATUS_WRITE; // [RULE19]
  assign do_flush = sel_rise && state_r == sfcfe_pkg::ST_DATA_IN &&
    cmd_r == sfcfe_pkg::CMD_PAGE_PROGRAM && !do_prog; // [RULE18]

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      write_enable_latch <= 1'b0; // [RULE19]
      level_r <= sfcfe_pkg::LEVEL_NONE;
      status_write_disable <= 1'b0;
      deep_powerdown <= 1'b0;
    end else if (frame_ok && in_wait) begin
      case (cmd_r)
        sfcfe_pkg::CMD_WRITE_ENABLE: write_enable_latch <= 1'b1;
        sfcfe_pkg::CMD_WRITE_DISABLE: write_enable_latch <= 1'b0;
        sfcfe_pkg::CMD_POWERDOWN_ENTER: deep_powerdown <= 1'b1;
        sfcfe_pkg::CMD_POWERDOWN_EXIT: deep_powerdown <= 1'b0; // [RULE22]
        default: begin
          if (do_erase) begin
            write_enable_latch <= 1'b0; // [RULE19]
          end
        end
      endcase
    end else if (do_prog) begin
      write_enable_latch <= 1'b0; // [RULE19]
    end else if (do_swr) begin
      write_enable_latch <= 1'b0; // [RULE19]
      if (!hw_protect) begin
        level_r <= {sw_byte_r[sfcfe_pkg::SR_LEVEL1_POS],
                    sw_byte_r[sfcfe_pkg::SR_LEVEL0_POS]}; // [RULE21]
        status_write_disable <= sw_byte_r[sfcfe_pkg::SR_LOCK_POS];
      end
    end
  end

  assign protect_level_bit0 = level_r[0];
  assign protect_level_bit1 = level_r[1];

  // launched ops run on in the back end regardless of pause
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      op_start <= 1'b0;
      op_kind <= sfcfe_pkg::OP_PROGRAM;
      op_addr <= 24'h000000;
      prog_flush <= 1'b0;
    end else begin
      op_start <= do_erase || do_prog; // [RULE16]
      prog_flush <= do_flush;
      if (do_prog) begin
        op_kind <= sfcfe_pkg::OP_PROGRAM; // [RULE8]
        op_addr <= addr_r;
      end else if (do_erase) begin
        if (cmd_r == sfcfe_pkg::CMD_SECTOR_ERASE) begin
          op_kind <= sfcfe_pkg::OP_SECTOR; // [RULE8]
          op_addr <= addr_r & sfcfe_pkg::SECTOR_MASK; // [RULE9]
        end else if (is_block) begin
          op_kind <= sfcfe_pkg::OP_BLOCK; // [RULE8]
          op_addr <= addr_r & sfcfe_pkg::BLOCK_MASK; // [RULE10]
        end else begin
          op_kind <= sfcfe_pkg::OP_CHIP; // [RULE8]
          op_addr <= 24'h000000;
        end
      end
    end
  end

  assign write_in_progress = array_busy | op_start; // [RULE11]
  assign standby = (seln || state_r == sfcfe_pkg::ST_IGNORE) &&
    !write_in_progress; // [RULE2] [RULE3]

  // page bytes beyond one page are dropped, not wrapped
  assign push_valid = byte_done && cmd_r == sfcfe_pkg::CMD_PAGE_PROGRAM &&
    nbytes_r < sfcfe_pkg::PAGE_BYTES; // [RULE8]

  sfcfe_fifo #(
    .WIDTH(sfcfe_pkg::DATA_W),
    .DEPTH(sfcfe_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .flush(prog_flush),
    .in_data(in_next[7:0]),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(prog_data),
    .out_valid(prog_valid),
    .out_ready(prog_ready)
  );
endmodule : sfcfe_top

// File: pkg/sfcfe_pkg.sv
package sfcfe_pkg;
  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_ID_READ = 8'h9f;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_ARRAY_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [7:0] CMD_DUAL_READ = 8'h3b;
  localparam logic [7:0] CMD_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE_A = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ERASE_B = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_POWERDOWN_ENTER = 8'hb9;
  localparam logic [7:0] CMD_POWERDOWN_EXIT = 8'hab;
  // status byte layout
  localparam int SR_BUSY_POS = 0;
  localparam int SR_LATCH_POS = 1;
  localparam int SR_LEVEL0_POS = 2;
  localparam int SR_LEVEL1_POS = 3;
  localparam int SR_LOCK_POS = 7;
  // framing
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] FAST_DUMMY_CLKS = 5'h08;
  localparam logic [4:0] QUAD_DUMMY_CLKS = 5'h06;
  localparam logic [2:0] LANES_SINGLE = 3'h1;
  localparam logic [2:0] LANES_DUAL = 3'h2;
  localparam logic [2:0] LANES_QUAD = 3'h4;
  localparam logic [5:0] NBYTES_MAX = 6'h3f;
  localparam logic [5:0] PAGE_BYTES = 6'h20;
  localparam logic [1:0] ID_LAST = 2'h2;
  // array organisation
  localparam logic [23:0] SECTOR_MASK = 24'hfff000;
  localparam logic [23:0] BLOCK_MASK = 24'hff0000;
  localparam logic [23:0] SMALL_TOP = 24'h00ffff;
  localparam logic [23:0] LARGE_TOP = 24'h01ffff;
  localparam int UPPER_BLOCK_POS = 16;
  // protect levels
  localparam logic [1:0] LEVEL_NONE = 2'h0;
  localparam logic [1:0] LEVEL_ONE_BLOCK = 2'h1;
  // buffering and reset values
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int PIN_COUNT = 6;
  localparam logic [5:0] PIN_IDLE = 6'h3f;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA_IN,
    ST_DATA_OUT,
    ST_WAIT,
    ST_IGNORE
  } sfcfe_state_type;

  typedef enum logic [1:0] {
    OP_PROGRAM,
    OP_SECTOR,
    OP_BLOCK,
    OP_CHIP
  } sfcfe_op_type;
endpackage : sfcfe_pkg

// File: hdl/sfcfe_sync.sv
`timescale 1ns/1ps
module sfcfe_sync #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  // meta_r feeds dout only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= INIT;
      dout <= INIT;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : sfcfe_sync

// File: hdl/sfcfe_fifo.sv
`timescale 1ns/1ps
module sfcfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic flush,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready = count_r != CW'(DEPTH);
  assign out_valid = count_r != '0;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_r[rd_r];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_r <= bump(wr_r);
      end
      if (pop) begin
        rd_r <= bump(rd_r);
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : sfcfe_fifo

// File: testbench/sfcfe_asserts.sv
`timescale 1ns/1ps
module sfcfe_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // watched ports
  input wire logic select_n_pin,
  input wire logic protect_n_pin,
  input wire logic array_busy,
  input wire logic op_start,
  input wire sfcfe_pkg::sfcfe_op_type op_kind,
  input wire logic [23:0] op_addr,
  input wire logic data_out_line1_oe,
  input wire logic write_enable_latch,
  input wire logic protect_level_bit0,
  input wire logic protect_level_bit1
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence sel_idle;
    select_n_pin [*6];
  endsequence
  sequence pin_low;
    !protect_n_pin [*4];
  endsequence
  a_one_pulse: assert property (
    op_start |=> !op_start) else $error("start too long");
  a_latch_used: assert property (
    op_start |-> $past(write_enable_latch) && !write_enable_latch)
    else $error("latch");
  a_busy_ignore: assert property (
    array_busy |-> !op_start) else $error("start while busy");
  a_sector_base: assert property (
    op_start && op_kind == sfcfe_pkg::OP_SECTOR |-> op_addr[11:0] == 12'h000)
    else $error("sector base");
  a_block_base: assert property (
    op_start && op_kind == sfcfe_pkg::OP_BLOCK |-> op_addr[15:0] == 16'h0)
    else $error("block base");
  a_chip_open: assert property (
    op_start && op_kind == sfcfe_pkg::OP_CHIP
      |-> !protect_level_bit0 && !protect_level_bit1) else $error("chip");
  a_idle_quiet: assert property (
    sel_idle |-> !data_out_line1_oe) else $error("drive in standby");
  a_level_held: assert property (
    pin_low |=> $stable({protect_level_bit1, protect_level_bit0}))
    else $error("level changed");
endmodule : sfcfe_asserts
bind sfcfe_top sfcfe_asserts sfcfe_asserts_inst (.*);

// File: testbench/sfcfe_host.sv
`timescale 1ns/1ps
module sfcfe_host (
  // clock
  input wire logic sys_clk,
  // link pins
  input wire logic miso,
  output logic sel_n,
  output logic sclk,
  output logic mosi
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask : half
  // clock stands at its idle level outside frames
  task automatic xfer(input logic [95:0] tx, input int n, input bit cpol,
                      output logic [95:0] rx);
    sclk = cpol;
    half();
    sel_n = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      half();
      sclk = 1'b1;
      half();
      rx = {rx[94:0], miso};
    end
    sclk = cpol;
    half();
    sel_n = 1'b1;
    mosi = ~mosi;
    repeat (2) half();
  endtask : xfer
endmodule : sfcfe_host

// File: testbench/sfcfe_tb_top.sv
`timescale 1ns/1ps
module sfcfe_tb_top;
  logic sys_clk = 1'b0, nrst = 1'b0, mosi, protect_n_pin = 1'b1;
  logic pause_n_pin = 1'b1, prog_ready = 1'b1, select_n_pin, serial_clock;
  logic data_in_line0_drv, data_in_line0_oe, data_out_line1_drv, op_start;
  logic data_out_line1_oe, protect_n_pin_drv, protect_n_pin_oe, prog_flush;
  logic pause_n_pin_drv, pause_n_pin_oe, prog_valid, write_in_progress;
  logic write_enable_latch, protect_level_bit0, protect_level_bit1, standby;
  logic status_write_disable, deep_powerdown, page_overrun;
  logic [23:0] op_addr, rd_addr, got;
  logic [7:0] prog_data, busy_cnt = 8'h00;
  logic [95:0] rx;
  sfcfe_pkg::sfcfe_op_type op_kind;
  int n_errors = 0, cmp_count = 0;
  wire logic array_busy = busy_cnt != 8'h00;
  wire logic [7:0] rd_data = rd_addr[7:0];
  wire logic data_in_line0 = data_in_line0_oe ? data_in_line0_drv : mosi;
  wire logic data_out_line1 = data_out_line1_oe ? data_out_line1_drv : 1'b1;
  sfcfe_top sfcfe_top_inst (.*);
  sfcfe_host sfcfe_host_inst (.sys_clk(sys_clk), .miso(data_out_line1),
    .sel_n(select_n_pin), .sclk(serial_clock), .mosi(mosi));
  always #25 sys_clk = ~sys_clk;
  // busy long enough to span a status read and a refused command
  always @(posedge sys_clk) begin
    if (op_start) begin
      busy_cnt <= 8'hff;
      got <= {op_kind, op_addr[21:0]};
    end else if (busy_cnt != 8'h00)
      busy_cnt <= busy_cnt - 8'h01;
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cmd(input logic [95:0] tx, input int n, input bit m3 = 0);
    sfcfe_host_inst.xfer(tx, n, m3, rx);
  endtask : cmd
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic wait_idle();
    for (int i = 0; i < 400 && array_busy; i++)
      @(negedge sys_clk);
    if (array_busy) begin
      n_errors++;
      end_sim();
    end
  endtask : wait_idle
  task automatic t_latch();
    cmd({8'h03, 24'h01fffe, 24'h000000}, 56);
    chk(rx[23:0], 24'hfeff00);
    cmd(96'h0c, 9);
    chk(write_enable_latch, 1'b0);
    cmd(96'h06, 8, 1'b1);
    chk(write_enable_latch, 1'b1);
    cmd(96'h0500, 16);
    chk(rx[7:0], 8'h01 << sfcfe_pkg::SR_LATCH_POS);
    cmd(96'h04, 8);
    chk(write_enable_latch, 1'b0);
    $display("t_latch end");
  endtask : t_latch
  task automatic t_erase();
    logic [31:0] c [4] = '{32'h20012345, 32'hd8012345, 32'hc7, 32'h52012345};
    logic [23:0] e [4] = '{24'h412000, 24'h810000, 24'hc00000, 24'h810000};
    for (int i = 0; i < 4; i++) begin
      cmd(96'h06, 8);
      cmd(c[i], i == 2 ? 8 : 32);
      chk(got, e[i]);
      chk(write_enable_latch, 1'b0);
      chk(standby, 1'b0);
      cmd(96'h0500, 16);
      chk(rx[0], 1'b1);
      cmd(96'h06, 8);
      chk(write_enable_latch, 1'b0);
      wait_idle();
    end
    $display("t_erase end");
  endtask : t_erase
  task automatic t_protect();
    protect_n_pin = 1'b0;
    cmd(96'h06, 8);
    cmd(96'h0104, 16);
    chk(protect_level_bit0, 1'b0);
    protect_n_pin = 1'b1;
    cmd(96'h06, 8);
    cmd(96'h0104, 16);
    chk(protect_level_bit0, 1'b1);
    cmd(96'h06, 8);
    cmd(96'h60, 8);
    chk(got, 24'h810000);
    $display("t_protect end");
  endtask : t_protect
  task automatic t_rest();
    prog_ready = 1'b0;
    cmd(96'h06, 8);
    cmd({8'h02, 24'h000100, 48'h0}, 80);
    chk(page_overrun, 1'b1);
    chk(prog_valid, 1'b1);
    wait_idle();
    pause_n_pin = 1'b0;
    cmd(96'h06, 8);
    chk(write_enable_latch, 1'b0);
    pause_n_pin = 1'b1;
    cmd(96'hb9, 8);
    chk(deep_powerdown, 1'b1);
    cmd(96'h06, 8);
    chk(write_enable_latch, 1'b0);
    cmd(96'hab, 8);
    chk(deep_powerdown, 1'b0);
    $display("t_rest end");
  endtask : t_rest
  initial begin
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    t_latch();
    t_erase();
    t_protect();
    t_rest();
    end_sim();
  end
endmodule : sfcfe_tb_top
